// *** hw/pcam_pkg.sv ***
package pcam_pkg;

  // clock and strobe timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int COUNT_PULSE_NS = 100;
  localparam int COUNT_PULSE_CYCLES = (COUNT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int COUNT_GAP_CYCLES = COUNT_PULSE_CYCLES;
  localparam int COUNT_PULSES = 2;

  // word and field widths
  localparam int PC_WIDTH = 16;
  localparam int NIBBLE_WIDTH = 4;
  localparam int NIBBLES = 4;
  localparam int AUX_ENTRIES = 16;
  localparam int AUX_ADDR_WIDTH = 4;
  localparam int RAM_WORD_WIDTH = 11;
  localparam int RAM_GROUPS = 4;
  localparam int BOARD_SELECTS = 4;

  // address bit positions in the pc register
  localparam int ADDR_GROUP_LO_BIT = 0;
  localparam int ADDR_GROUP_HI_BIT = 4;
  localparam int ADDR_HALF_BIT = 13;
  localparam int ADDR_BOARD_LO_BIT = 14;
  localparam int ADDR_BOARD_HI_BIT = 15;

  // ram address lines driven inverted (bits 3, 4, 5 and 10)
  localparam logic [10:0] RAM_ADDR_INVERT_MASK = 11'h438;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  // alu function encodings
  typedef enum logic [3:0] {
    PCAM_ALU_ADD = 4'h0,
    PCAM_ALU_OR = 4'h1,
    PCAM_ALU_PASS_B = 4'h2,
    PCAM_ALU_XNOR = 4'h3
  } pcam_alu_fn_type;

  // phase order positions within one machine cycle
  localparam logic [2:0] ORD_ADDR_LATCH = 3'h0;
  localparam logic [2:0] ORD_REG_LOAD = 3'h1;
  localparam logic [2:0] ORD_COUNT = 3'h2;
  localparam logic [2:0] ORD_AUX_WRITE = 3'h3;
  localparam logic [2:0] ORD_RELEASE = 3'h4;
  localparam logic [2:0] ORD_WRITE_CLOCK = 3'h5;
  localparam logic [2:0] ORD_FETCH = 3'h6;

endpackage : pcam_pkg

// *** hw/pcam_ram_groups.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcam_ram_groups #(
  parameter int GROUPS = 4,
  parameter int NIB = 4,
  parameter int AW = 12
) (
  input wire logic mclk,
  input wire logic [AW-1:0] addr,
  input wire logic [GROUPS-1:0] write_enable,
  input wire logic [NIB-1:0] wdata,
  output logic [GROUPS*NIB-1:0] rdata
);

  // one nibble-wide array per ram group, all sharing one address
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : grp
      logic [NIB-1:0] mem [0:(1<<AW)-1];

      // write only the enabled group, read every group
      always_ff @(posedge mclk) begin
        if (write_enable[g]) begin
          mem[addr] <= wdata;
        end
        rdata[g*NIB +: NIB] <= mem[addr];
      end
    end
  endgenerate

endmodule : pcam_ram_groups

`default_nettype wire

// *** hw/pcam_datapath.sv ***
// Summary of operation
// RL1: address-latch phase copies pc register to address
// RL2: top two address bits pick board select
// RL3: bits zero, four pick one ram group
// RL4: bit thirteen selects lower or upper half
// RL5: ram address from bits 1-3, 5 up
// RL6: group writes build eight-bit word, read whole
// RL7: increment by two: two 100 ns pulses
// RL8: aux write strobe stores counter at entry
// RL9: no source select: aux output loads pc
// RL10: aux holds complement, load path inverts back
// RL11: exchange first loads counter from pc register
// RL12: c-bus select loads only the decoded nibble
// RL13: decoders enabled only with ram status low
// RL14: exchange sets alu logic pass-through
// RL15: or instruction sets alu logical or
// RL16: cycle-end phase clears select and enable latches
// RL17: phase strobes must follow the fixed order
`timescale 1ns/10ps
`default_nettype none

module pcam_datapath #(
  parameter int PULSE_CYCLES = pcam_pkg::COUNT_PULSE_CYCLES,
  parameter int GAP_CYCLES = pcam_pkg::COUNT_GAP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_latch_phase,
  input wire logic reg_load_phase,
  input wire logic count_phase,
  input wire logic aux_write_phase,
  input wire logic write_release_phase,
  input wire logic write_clock_phase,
  input wire logic pc_nibble_capture_phase,
  input wire logic fetch_phase,
  input wire logic cycle_end_phase,
  input wire logic op_exchange,
  input wire logic op_inc_two,
  input wire logic op_or,
  input wire logic op_mem_access,
  input wire logic immediate_source_select,
  input wire logic cbus_source_select,
  input wire logic memsize_source_select,
  input wire logic [1:0] nibble_field,
  input wire logic [3:0] aux_addr,
  input wire logic ram_access_status_bit,
  input wire logic [3:0] cbus_data,
  input wire logic [3:0] immediate_data,
  input wire logic [3:0] memsize_data,
  output logic [15:0] dm_addr,
  output logic [3:0] board_select,
  output logic [3:0] ram_group_write_enable,
  output logic [10:0] ram_word_addr,
  output logic ram_half_select,
  output logic [3:0] read_nibble,
  output logic [7:0] read_byte,
  output logic [15:0] pc_reg,
  output logic [15:0] prog_counter,
  output logic pc_count_strobe,
  output logic aux_file_write_strobe,
  output logic [3:0] pc_nibble_strobe,
  output logic [3:0] pc_low_capture,
  output logic alu_logic_mode,
  output pcam_pkg::pcam_alu_fn_type alu_function,
  output logic phase_order_error
);

  // one-hot decode of a two-bit select
  function automatic logic [3:0] onehot4(input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h0;
    r[sel] = 1'b1;
    return r;
  endfunction : onehot4

  typedef enum {
    PCAM_CNT_IDLE,
    PCAM_CNT_HIGH,
    PCAM_CNT_LOW
  } pcam_cnt_state_type;

  logic [15:0] aux_file [0:pcam_pkg::AUX_ENTRIES-1];
  logic [3:0] board_latch;
  logic [3:0] wen_latch;
  logic [15:0] aux_word;
  logic [3:0] next_src [0:3];
  logic pc_gate_select;
  logic [3:0] next_strobe;
  logic [10:0] word_logical;
  logic [11:0] ram_addr_full;
  logic [3:0] ram_write;
  logic [15:0] ram_rdata;
  logic [1:0] group_sel;
  pcam_cnt_state_type cnt_state;
  logic [7:0] cnt_timer;
  logic [1:0] pulses_done;
  logic [2:0] last_phase;
  logic phase_seen;

  // gate signal for whole-register transfers
  assign pc_gate_select = op_exchange | memsize_source_select;

  // auxiliary file read, stored complemented
  assign aux_word = ~aux_file[aux_addr]; // RL10

  // pc register source selector, one nibble each
  genvar n;
  generate
    for (n = 0; n < pcam_pkg::NIBBLES; n++) begin : src
      always_comb begin
        if (immediate_source_select) begin
          next_src[n] = immediate_data;
        end else if (cbus_source_select) begin
          next_src[n] = cbus_data; // RL12
        end else if (memsize_source_select) begin
          next_src[n] = (n == pcam_pkg::NIBBLES - 1) ? memsize_data : pcam_pkg::NIBBLE_RESET;
        end else begin
          next_src[n] = aux_word[n*4 +: 4]; // RL9
        end
      end
    end
  endgenerate

  // nibble strobe decode for this reg-load phase
  always_comb begin
    next_strobe = 4'h0;
    if (reg_load_phase) begin
      if (pc_gate_select) begin
        next_strobe = 4'hF; // RL9
      end else if (cbus_source_select || immediate_source_select) begin
        next_strobe = onehot4(nibble_field); // RL12
      end
    end
  end

  // pc register nibbles loaded by their strobes
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_reg <= pcam_pkg::PC_RESET;
      pc_nibble_strobe <= 4'h0;
    end else begin
      pc_nibble_strobe <= next_strobe;
      for (int i = 0; i < pcam_pkg::NIBBLES; i++) begin
        if (next_strobe[i]) begin
          pc_reg[i*4 +: 4] <= next_src[i]; // RL9 RL10 RL12
        end
      end
    end
  end

  // data memory address register and ram address map
  always_ff @(posedge mclk) begin
    if (rst) begin
      dm_addr <= pcam_pkg::PC_RESET;
      ram_word_addr <= 11'h000;
      ram_half_select <= 1'b0;
    end else if (addr_latch_phase) begin
      dm_addr <= pc_reg; // RL1
      ram_word_addr <= word_logical ^ pcam_pkg::RAM_ADDR_INVERT_MASK; // RL5
      ram_half_select <= pc_reg[pcam_pkg::ADDR_HALF_BIT]; // RL4
    end
  end

  // word address: bits 1..3 then 5..12; bit 13 picks the half
  assign word_logical = {pc_reg[12:5], pc_reg[3:1]}; // RL5

  // select and write enable latches
  always_ff @(posedge mclk) begin
    if (rst) begin
      board_latch <= 4'h0;
      wen_latch <= 4'h0;
    end else if (cycle_end_phase) begin
      board_latch <= 4'h0; // RL16
      wen_latch <= 4'h0; // RL16
    end else if (addr_latch_phase) begin
      if (op_mem_access && !ram_access_status_bit) begin // RL13
        board_latch <= onehot4(pc_reg[pcam_pkg::ADDR_BOARD_HI_BIT:pcam_pkg::ADDR_BOARD_LO_BIT]); // RL2
        wen_latch <= onehot4({pc_reg[pcam_pkg::ADDR_GROUP_HI_BIT],
                              pc_reg[pcam_pkg::ADDR_GROUP_LO_BIT]}); // RL3
      end else begin
        board_latch <= 4'h0;
        wen_latch <= 4'h0;
      end
    end
  end

  // drive selects; write enable only applied after release
  always_ff @(posedge mclk) begin
    if (rst) begin
      board_select <= 4'h0;
      ram_group_write_enable <= 4'h0;
    end else if (cycle_end_phase) begin
      board_select <= 4'h0; // RL16
      ram_group_write_enable <= 4'h0; // RL16
    end else begin
      board_select <= board_latch;
      if (write_release_phase) begin
        ram_group_write_enable <= wen_latch; // RL3
      end
    end
  end

  // group storage, write clocked by the write-clock phase
  assign ram_write = write_clock_phase ? ram_group_write_enable : 4'h0; // RL6
  assign ram_addr_full = {ram_half_select, ram_word_addr};

  pcam_ram_groups #(
    .GROUPS(pcam_pkg::RAM_GROUPS),
    .NIB(pcam_pkg::NIBBLE_WIDTH),
    .AW(12)
  ) u_ram (
    .mclk(mclk),
    .addr(ram_addr_full),
    .write_enable(ram_write),
    .wdata(cbus_data),
    .rdata(ram_rdata)
  );

  // read buffers: addressed group nibble and whole byte
  assign group_sel = {dm_addr[pcam_pkg::ADDR_GROUP_HI_BIT], dm_addr[pcam_pkg::ADDR_GROUP_LO_BIT]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      read_nibble <= 4'h0;
      read_byte <= 8'h00;
    end else begin
      read_nibble <= ram_rdata[group_sel*4 +: 4]; // RL3
      read_byte <= {ram_rdata[{group_sel[1], 1'b1}*4 +: 4],
                    ram_rdata[{group_sel[1], 1'b0}*4 +: 4]}; // RL6
    end
  end

  // count strobe: two timed pulses, one count per pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_state <= PCAM_CNT_IDLE;
      cnt_timer <= 8'h00;
      pulses_done <= 2'h0;
      pc_count_strobe <= 1'b0;
    end else begin
      case (cnt_state)
        PCAM_CNT_IDLE: begin
          if (count_phase && op_exchange && op_inc_two) begin // RL7
            cnt_state <= PCAM_CNT_HIGH;
            cnt_timer <= 8'(PULSE_CYCLES - 1);
            pulses_done <= 2'h0;
            pc_count_strobe <= 1'b1;
          end
        end
        PCAM_CNT_HIGH: begin
          if (cnt_timer == 8'h00) begin
            pc_count_strobe <= 1'b0;
            pulses_done <= pulses_done + 2'h1;
            if (pulses_done == 2'(pcam_pkg::COUNT_PULSES - 1)) begin
              cnt_state <= PCAM_CNT_IDLE; // RL7
            end else begin
              cnt_state <= PCAM_CNT_LOW;
              cnt_timer <= 8'(GAP_CYCLES - 1);
            end
          end else begin
            cnt_timer <= cnt_timer - 8'h01;
          end
        end
        PCAM_CNT_LOW: begin
          if (cnt_timer == 8'h00) begin
            cnt_state <= PCAM_CNT_HIGH;
            cnt_timer <= 8'(PULSE_CYCLES - 1);
            pc_count_strobe <= 1'b1;
          end else begin
            cnt_timer <= cnt_timer - 8'h01;
          end
        end
        default: begin
          cnt_state <= PCAM_CNT_IDLE;
          pc_count_strobe <= 1'b0;
        end
      endcase
    end
  end

  // program counter: load from pc register, step on strobe rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_counter <= pcam_pkg::PC_RESET;
    end else if (addr_latch_phase && op_exchange) begin
      prog_counter <= pc_reg; // RL11
    end else if (cnt_state == PCAM_CNT_HIGH && cnt_timer == 8'(PULSE_CYCLES - 1)
                 && pc_count_strobe) begin
      prog_counter <= prog_counter + 16'h0001; // RL7
    end
  end

  // auxiliary file write, complemented
  always_ff @(posedge mclk) begin
    if (aux_write_phase && op_exchange) begin
      aux_file[aux_addr] <= ~prog_counter; // RL8 RL10
    end
  end

  // write strobe pulse and low nibble capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      aux_file_write_strobe <= 1'b0;
      pc_low_capture <= 4'h0;
    end else begin
      aux_file_write_strobe <= aux_write_phase && op_exchange; // RL8
      if (pc_nibble_capture_phase) begin
        pc_low_capture <= pc_reg[3:0];
      end
    end
  end

  // alu mode and function decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      alu_logic_mode <= 1'b0;
      alu_function <= pcam_pkg::PCAM_ALU_ADD;
    end else if (op_exchange) begin
      alu_logic_mode <= 1'b1; // RL14
      alu_function <= pcam_pkg::PCAM_ALU_PASS_B; // RL14
    end else if (op_or) begin
      alu_logic_mode <= 1'b1; // RL15
      alu_function <= pcam_pkg::PCAM_ALU_OR; // RL15
    end else begin
      alu_logic_mode <= 1'b0;
      alu_function <= pcam_pkg::PCAM_ALU_ADD;
    end
  end

  // phase order watch: flags a strobe earlier than the last one
  always_ff @(posedge mclk) begin
    if (rst) begin
      last_phase <= pcam_pkg::ORD_ADDR_LATCH;
      phase_seen <= 1'b0;
      phase_order_error <= 1'b0;
    end else if (cycle_end_phase || fetch_phase) begin
      phase_seen <= 1'b0;
      last_phase <= pcam_pkg::ORD_ADDR_LATCH;
    end else if (addr_latch_phase) begin
      if (phase_seen) begin
        phase_order_error <= 1'b1; // RL17
      end
      phase_seen <= 1'b1;
      last_phase <= pcam_pkg::ORD_ADDR_LATCH;
    end else if (reg_load_phase || count_phase || aux_write_phase
                 || write_release_phase || write_clock_phase) begin
      if (!phase_seen || phase_index() < last_phase) begin
        phase_order_error <= 1'b1; // RL17
      end
      last_phase <= phase_index();
    end
  end

  // position of the strobe present this cycle
  function automatic logic [2:0] phase_index();
    logic [2:0] r;
    r = pcam_pkg::ORD_FETCH;
    if (reg_load_phase) begin
      r = pcam_pkg::ORD_REG_LOAD;
    end else if (count_phase) begin
      r = pcam_pkg::ORD_COUNT;
    end else if (aux_write_phase) begin
      r = pcam_pkg::ORD_AUX_WRITE;
    end else if (write_release_phase) begin
      r = pcam_pkg::ORD_RELEASE;
    end else if (write_clock_phase) begin
      r = pcam_pkg::ORD_WRITE_CLOCK;
    end
    return r;
  endfunction : phase_index

endmodule : pcam_datapath

`default_nettype wire

// *** dv/pcam_datapath_props.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcam_datapath_props #(
  parameter int PULSE_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_latch_phase,
  input wire logic reg_load_phase,
  input wire logic aux_write_phase,
  input wire logic cycle_end_phase,
  input wire logic op_exchange,
  input wire logic immediate_source_select,
  input wire logic cbus_source_select,
  input wire logic [1:0] nibble_field,
  input wire logic ram_access_status_bit,
  input wire logic [15:0] pc_reg,
  input wire logic [15:0] dm_addr,
  input wire logic [3:0] board_select,
  input wire logic [3:0] ram_group_write_enable,
  input wire logic [10:0] ram_word_addr,
  input wire logic ram_half_select,
  input wire logic pc_count_strobe,
  input wire logic aux_file_write_strobe,
  input wire logic [3:0] pc_nibble_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // length of the current count strobe pulse
  int run;
  always_ff @(posedge mclk) begin
    if (rst || !pc_count_strobe) run <= 0;
    else run <= run + 1;
  end
  // address register and ram address mapping
  addr_latch_a: assert property (addr_latch_phase |=> dm_addr == $past(pc_reg))
    else $error("address register missed the pc register");
  half_select_a: assert property (addr_latch_phase |=> ram_half_select == $past(pc_reg[13]))
    else $error("half select not taken from bit thirteen");
  word_addr_a: assert property (addr_latch_phase |=> ram_word_addr ==
    ({$past(pc_reg[12:5]), $past(pc_reg[3:1])} ^ pcam_pkg::RAM_ADDR_INVERT_MASK))
    else $error("ram word address mapping wrong");
  // decoders
  board_decode_a: assert property (board_select != 4'h0 && !$past(addr_latch_phase)
    |-> board_select == (4'h1 << dm_addr[15:14]))
    else $error("board select does not match address");
  group_decode_a: assert property (ram_group_write_enable != 4'h0
    |-> ram_group_write_enable == (4'h1 << {dm_addr[4], dm_addr[0]}))
    else $error("group enable does not match address");
  status_block_a: assert property (addr_latch_phase && ram_access_status_bit
    |=> ##1 board_select == 4'h0)
    else $error("select decoded while ram status high");
  cycle_clear_a: assert property (cycle_end_phase
    |=> board_select == 4'h0 && ram_group_write_enable == 4'h0)
    else $error("cycle end left selects active");
  // strobes
  count_width_a: assert property ($fell(pc_count_strobe) |-> run == PULSE_CYCLES)
    else $error("count pulse width wrong");
  aux_strobe_a: assert property (aux_write_phase && op_exchange |=> aux_file_write_strobe)
    else $error("aux write strobe missing");
  nibble_only_a: assert property (reg_load_phase && cbus_source_select && !immediate_source_select
    && !op_exchange |=> pc_nibble_strobe == (4'h1 << nibble_field))
    else $error("wrong nibble strobe for bus load");
endmodule : pcam_datapath_props

bind pcam_datapath pcam_datapath_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .mclk(mclk), .rst(rst), .addr_latch_phase(addr_latch_phase),
  .reg_load_phase(reg_load_phase), .aux_write_phase(aux_write_phase),
  .cycle_end_phase(cycle_end_phase), .op_exchange(op_exchange),
  .immediate_source_select(immediate_source_select), .cbus_source_select(cbus_source_select),
  .nibble_field(nibble_field), .ram_access_status_bit(ram_access_status_bit),
  .pc_reg(pc_reg), .dm_addr(dm_addr), .board_select(board_select),
  .ram_group_write_enable(ram_group_write_enable), .ram_word_addr(ram_word_addr),
  .ram_half_select(ram_half_select), .pc_count_strobe(pc_count_strobe),
  .aux_file_write_strobe(aux_file_write_strobe), .pc_nibble_strobe(pc_nibble_strobe));

`default_nettype wire

// *** dv/pcam_ram_board.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcam_ram_board (
  input wire logic mclk,
  input wire logic write_clock_phase,
  input wire logic [3:0] ram_group_write_enable,
  input wire logic ram_half_select,
  input wire logic [10:0] ram_word_addr,
  input wire logic [3:0] cbus_data,
  output logic [15:0] row
);
  logic [3:0] mem [4][4096];
  logic [11:0] last_idx;
  // each enabled group takes the bus nibble at the write clock
  always_ff @(posedge mclk) begin
    if (write_clock_phase) begin
      for (int g = 0; g < 4; g++) begin
        if (ram_group_write_enable[g]) mem[g][{ram_half_select, ram_word_addr}] <= cbus_data;
      end
      last_idx <= {ram_half_select, ram_word_addr};
    end
  end
  // the four groups at the last written place
  assign row = {mem[3][last_idx], mem[2][last_idx], mem[1][last_idx], mem[0][last_idx]};
endmodule : pcam_ram_board

`default_nettype wire

// *** dv/pcam_datapath_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcam_datapath_tb;
  logic mclk, rst, addr_latch_phase, reg_load_phase, count_phase, aux_write_phase;
  logic write_release_phase, write_clock_phase, pc_nibble_capture_phase, fetch_phase;
  logic cycle_end_phase, op_exchange, op_inc_two, op_or, op_mem_access;
  logic immediate_source_select, cbus_source_select, memsize_source_select, ram_access_status_bit;
  logic [1:0] nibble_field;
  logic [3:0] aux_addr, cbus_data, immediate_data, memsize_data, board_select;
  logic [3:0] ram_group_write_enable, read_nibble, pc_nibble_strobe, pc_low_capture;
  logic [15:0] dm_addr, pc_reg, prog_counter, row;
  logic [10:0] ram_word_addr;
  logic [7:0] read_byte;
  logic ram_half_select, pc_count_strobe, aux_file_write_strobe, alu_logic_mode;
  logic phase_order_error;
  pcam_pkg::pcam_alu_fn_type alu_function;
  int bad_count = 0;
  int n_compared = 0;

  pcam_datapath #(.PULSE_CYCLES(2), .GAP_CYCLES(2)) dut (.mclk, .rst, .addr_latch_phase,
    .reg_load_phase, .count_phase, .aux_write_phase, .write_release_phase, .write_clock_phase,
    .pc_nibble_capture_phase, .fetch_phase, .cycle_end_phase, .op_exchange, .op_inc_two, .op_or,
    .op_mem_access, .immediate_source_select, .cbus_source_select, .memsize_source_select,
    .nibble_field, .aux_addr, .ram_access_status_bit, .cbus_data, .immediate_data,
    .memsize_data, .dm_addr, .board_select, .ram_group_write_enable, .ram_word_addr,
    .ram_half_select, .read_nibble, .read_byte, .pc_reg, .prog_counter, .pc_count_strobe,
    .aux_file_write_strobe, .pc_nibble_strobe, .pc_low_capture, .alu_logic_mode,
    .alu_function, .phase_order_error);
  pcam_ram_board board (.mclk, .write_clock_phase, .ram_group_write_enable, .ram_half_select,
    .ram_word_addr, .cbus_data, .row);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // one-cycle phase strobe, raised and dropped at falling edges
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse

  // load the pc register one nibble at a time from the c bus
  task load_pc(input logic [15:0] v);
    cbus_source_select = 1'b1;
    for (int n = 0; n < 4; n++) begin
      nibble_field = n[1:0];
      cbus_data = v[4*n+:4];
      pulse(addr_latch_phase);
      pulse(reg_load_phase);
      pulse(fetch_phase);
    end
    cbus_source_select = 1'b0;
    check("pc_reg", pc_reg, v);
  endtask : load_pc

  // four writes at one word, one group each, then read back whole
  task test_group_writes(input logic [15:0] base);
    for (int g = 0; g < 4; g++) begin
      load_pc(base | {11'h0, g[1], 3'h0, g[0]});
      cbus_data = 4'h3 + 4'(g * 5);
      op_mem_access = 1'b1;
      pulse(addr_latch_phase);
      @(negedge mclk);
      check("dm_addr", dm_addr, base | {11'h0, g[1], 3'h0, g[0]});
      check("board_select", {12'h0, board_select}, 16'h1 << base[15:14]);
      check("half", {15'h0, ram_half_select}, {15'h0, base[13]});
      check("word", {5'h0, ram_word_addr},
        {5'h0, {base[12:5], base[3:1]} ^ pcam_pkg::RAM_ADDR_INVERT_MASK});
      pulse(write_release_phase);
      @(negedge mclk);
      check("group_enable", {12'h0, ram_group_write_enable}, 16'h1 << g);
      pulse(write_clock_phase);
      pulse(cycle_end_phase);
      @(negedge mclk);
      check("cleared", {8'h0, board_select, ram_group_write_enable}, 16'h0);
      op_mem_access = 1'b0;
    end
    repeat (3) @(negedge mclk);
    check("board_row", row, 16'h2D83);
    check("read_byte", {8'h0, read_byte}, 16'h002D);
    check("read_nibble", {12'h0, read_nibble}, 16'h0002);
  endtask : test_group_writes

  // decode refused while the ram status bit is high
  task test_status_block();
    op_mem_access = 1'b1;
    ram_access_status_bit = 1'b1;
    pulse(addr_latch_phase);
    pulse(write_release_phase);
    repeat (2) @(negedge mclk);
    check("blocked", {8'h0, board_select, ram_group_write_enable}, 16'h0);
    pulse(cycle_end_phase);
    op_mem_access = 1'b0;
    ram_access_status_bit = 1'b0;
  endtask : test_status_block

  // exchange with +2 then plain exchange returns the stepped value
  task test_exchange(input logic [15:0] p);
    load_pc(p);
    aux_addr = 4'hA;
    op_exchange = 1'b1;
    op_inc_two = 1'b1;
    pulse(addr_latch_phase);
    @(negedge mclk); // no reg-load strobe yet, so no pc reload yet
    check("alu_mode", {15'h0, alu_logic_mode}, 16'h1);
    check("alu_fn", 16'(alu_function), 16'(pcam_pkg::PCAM_ALU_PASS_B));
    pulse(count_phase);
    repeat (12) @(negedge mclk);
    check("prog_counter", prog_counter, p + 16'h2);
    pulse(aux_write_phase);
    pulse(fetch_phase);
    op_inc_two = 1'b0;
    pulse(addr_latch_phase);
    pulse(reg_load_phase);
    check("pc_back", pc_reg, p + 16'h2);
    pulse(pc_nibble_capture_phase);
    check("low_capture", {12'h0, pc_low_capture}, {12'h0, p[3:0] + 4'h2});
    pulse(fetch_phase);
    op_exchange = 1'b0;
    check("order_ok", {15'h0, phase_order_error}, 16'h0);
  endtask : test_exchange

  // or instruction and an out-of-order strobe
  task test_or_and_order();
    memsize_source_select = 1'b1;
    pulse(addr_latch_phase);
    pulse(reg_load_phase);
    pulse(fetch_phase);
    memsize_source_select = 1'b0;
    check("memsize_load", pc_reg, {memsize_data, 12'h000});
    immediate_source_select = 1'b1;
    nibble_field = 2'h1;
    pulse(addr_latch_phase);
    pulse(reg_load_phase);
    pulse(fetch_phase);
    immediate_source_select = 1'b0;
    check("immediate_load", pc_reg, {memsize_data, 4'h0, immediate_data, 4'h0});
    op_or = 1'b1;
    repeat (2) @(negedge mclk);
    check("alu_or", 16'(alu_function), 16'(pcam_pkg::PCAM_ALU_OR));
    op_or = 1'b0;
    pulse(reg_load_phase);
    @(negedge mclk);
    check("order_err", {15'h0, phase_order_error}, 16'h1);
  endtask : test_or_and_order

  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {addr_latch_phase, reg_load_phase, count_phase, aux_write_phase, write_release_phase} = '0;
    {write_clock_phase, pc_nibble_capture_phase, fetch_phase, cycle_end_phase} = '0;
    {op_exchange, op_inc_two, op_or, op_mem_access, ram_access_status_bit} = '0;
    {immediate_source_select, cbus_source_select, memsize_source_select} = '0;
    nibble_field = 2'h0;
    aux_addr = 4'h0;
    cbus_data = 4'h0;
    immediate_data = 4'h5;
    memsize_data = 4'hE;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    check("reset_addr", dm_addr, 16'h0);
    check("reset_fn", 16'(alu_function), 16'(pcam_pkg::PCAM_ALU_ADD));
    test_group_writes(16'h6CE2);
    test_status_block();
    test_exchange(16'h0054);
    test_or_and_order();
    report_and_stop();
  end
endmodule : pcam_datapath_tb

`default_nettype wire
